// [hdl/lsr_consts.vh]
`ifndef LSR_CONSTS_VH
`define LSR_CONSTS_VH

// reset encodings of the four reports
`define LSR_RATE_RST        1'h0
`define LSR_WIDTH_RST       2'h0
`define LSR_STATE_RST       6'h00
`define LSR_LINKUP_N_RST    1'h1

// current rate report
`define LSR_RATE_2G5        1'h0
`define LSR_RATE_5G0        1'h1

// current width report
`define LSR_WIDTH_X1        2'h0
`define LSR_WIDTH_X2        2'h1
`define LSR_WIDTH_X4        2'h2
`define LSR_WIDTH_X8        2'h3

// raw lane counts from the training logic
`define LSR_LANES_1         4'h1
`define LSR_LANES_2         4'h2
`define LSR_LANES_4         4'h4
`define LSR_LANES_8         4'h8

// training phase codes presented by the training logic
`define LSR_PH_DETECT       4'h0
`define LSR_PH_POLLING      4'h1
`define LSR_PH_COMPLIANCE   4'h2
`define LSR_PH_CFG_WIDTH    4'h3
`define LSR_PH_CFG_LANE     4'h4
`define LSR_PH_CFG_DONE     4'h5
`define LSR_PH_CFG_IDLE     4'h6
`define LSR_PH_L0           4'h7
`define LSR_PH_L1           4'h8
`define LSR_PH_RECOVERY     4'h9
`define LSR_PH_HOT_RESET    4'ha
`define LSR_PH_DISABLED     4'hb

// state codes of each phase; stepped phases add the step to their base, complete adds the width code
`define LSR_ST_DETECT_QUIET 6'h00
`define LSR_ST_DETECT_ACT   6'h02
`define LSR_ST_POLL_ACTIVE  6'h04
`define LSR_ST_POLL_CONFIG  6'h05
`define LSR_ST_COMPLIANCE   6'h06
`define LSR_ST_CFG_WIDTH    6'h0b
`define LSR_ST_CFG_LANE     6'h0f
`define LSR_ST_CFG_DONE     6'h11
`define LSR_ST_CFG_IDLE     6'h15
`define LSR_ST_L0           6'h16
`define LSR_ST_L1_ENTRY     6'h17
`define LSR_ST_L23_READY    6'h19
`define LSR_ST_L1_IDLE      6'h1a
`define LSR_ST_L1_EXIT      6'h1b
`define LSR_ST_RECOVERY     6'h1c
`define LSR_ST_HOT_RESET    6'h21
`define LSR_ST_DISABLED     6'h22
`define LSR_ST_RP_CFG_W0    6'h26

// number of steps in each multi-step phase
`define LSR_STEPS_DETECT    3'h4
`define LSR_STEPS_POLLING   3'h2
`define LSR_STEPS_COMPLY    3'h5
`define LSR_STEPS_CFG_WIDTH 3'h4
`define LSR_STEPS_CFG_LANE  3'h2
`define LSR_STEPS_L1        3'h5
`define LSR_STEPS_RECOVERY  3'h5
`define LSR_STEPS_DISABLED  3'h4

`endif

// [hdl/lsr_width_enc.v]
`timescale 1ns/10ps
`default_nettype none
`include "lsr_consts.vh"

module lsr_width_enc (
    input  wire [3:0] lane_count,
    output reg  [1:0] width_code
);

    always @* begin
        case (lane_count)
            `LSR_LANES_2: width_code = `LSR_WIDTH_X2;
            `LSR_LANES_4: width_code = `LSR_WIDTH_X4;
            `LSR_LANES_8: width_code = `LSR_WIDTH_X8;
            default:      width_code = `LSR_WIDTH_X1;
        endcase
    end

endmodule // lsr_width_enc

`default_nettype wire

// [hdl/lsr_top.v]
`timescale 1ns/10ps
`default_nettype none
`include "lsr_consts.vh"

module lsr_top (
    input  wire       clock,
    input  wire       reset_n,
    input  wire       link_up_n,
    input  wire       rate_is_5g,
    input  wire [3:0] lane_count,
    input  wire [3:0] train_phase,
    input  wire [2:0] train_step,
    input  wire       l23_ready,
    input  wire       is_root_port,
    output wire       link_up_report_n,
    output wire       current_rate_report,
    output wire [1:0] current_width_report,
    output wire [5:0] training_state_code
);

    // registered reports and their next values
    reg        rate_q;
    reg  [1:0] width_q;
    reg  [5:0] state_q;
    reg        linkup_n_q;
    reg        rate_d;
    reg  [5:0] state_d;
    reg        linkup_n_d;
    wire [1:0] width_d;

    // step of every stepped phase after clamping
    reg  [2:0] detect_step;
    reg  [2:0] poll_step;
    reg  [2:0] comply_step;
    reg  [2:0] cfg_width_step;
    reg  [2:0] cfg_lane_step;
    reg  [2:0] l1_step;
    reg  [2:0] recovery_step;
    reg  [2:0] disabled_step;

    // candidate code of every phase with more than one code
    reg  [5:0] detect_code;
    reg  [5:0] poll_code;
    reg  [5:0] comply_code;
    reg  [5:0] cfg_width_code;
    reg  [5:0] cfg_lane_code;
    reg  [5:0] cfg_done_code;
    reg  [5:0] l1_code;
    reg  [5:0] recovery_code;
    reg  [5:0] disabled_code;

    // a step past the end of its phase holds the last step, so a step that
    // runs ahead of the phase never shows a code of the next phase
    function [2:0] clamp_step;
        input [2:0] step;
        input [2:0] steps;
        begin
            if (step < steps)
                clamp_step = step;
            else
                clamp_step = steps - 3'h1;
        end
    endfunction

    // base code of a phase plus the step within it
    function [5:0] step_code;
        input [5:0] base;
        input [2:0] step;
        begin
            step_code = base + {3'h0, step};
        end
    endfunction

    lsr_width_enc u_width (
        .lane_count (lane_count),
        .width_code (width_d)
    );

    always @* begin
        rate_d = rate_is_5g ? `LSR_RATE_5G0 : `LSR_RATE_2G5;
    end

    // link-up takes the same one-cycle path as the reports it qualifies
    always @* begin
        linkup_n_d = link_up_n;
    end

    // every stepped phase clamps by the same rule; only the step count differs
    always @* begin
        detect_step    = clamp_step(train_step, `LSR_STEPS_DETECT);
        poll_step      = clamp_step(train_step, `LSR_STEPS_POLLING);
        comply_step    = clamp_step(train_step, `LSR_STEPS_COMPLY);
        cfg_width_step = clamp_step(train_step, `LSR_STEPS_CFG_WIDTH);
        cfg_lane_step  = clamp_step(train_step, `LSR_STEPS_CFG_LANE);
        l1_step        = clamp_step(train_step, `LSR_STEPS_L1);
        recovery_step  = clamp_step(train_step, `LSR_STEPS_RECOVERY);
        disabled_step  = clamp_step(train_step, `LSR_STEPS_DISABLED);
    end

    always @* begin
        detect_code   = step_code(`LSR_ST_DETECT_QUIET, detect_step);
        poll_code     = step_code(`LSR_ST_POLL_ACTIVE, poll_step);
        comply_code   = step_code(`LSR_ST_COMPLIANCE, comply_step);
        l1_code       = step_code(`LSR_ST_L1_ENTRY, l1_step);
        recovery_code = step_code(`LSR_ST_RECOVERY, recovery_step);
        disabled_code = step_code(`LSR_ST_DISABLED, disabled_step);
    end

    // configuration codes; the complete substate follows the negotiated width
    always @* begin
        cfg_lane_code = step_code(`LSR_ST_CFG_LANE, cfg_lane_step);
        cfg_done_code = step_code(`LSR_ST_CFG_DONE, {1'h0, width_d});
        // the root port has its own code for linkwidth start 0
        if (is_root_port && train_step == 3'h0)
            cfg_width_code = `LSR_ST_RP_CFG_W0;
        else
            cfg_width_code = step_code(`LSR_ST_CFG_WIDTH, cfg_width_step);
    end

    // an unknown phase reports detect quiet, the safe idle meaning
    always @* begin
        state_d = `LSR_ST_DETECT_QUIET;
        case (train_phase)
            `LSR_PH_DETECT: begin
                state_d = detect_code;
            end
            `LSR_PH_POLLING: begin
                state_d = poll_code;
            end
            `LSR_PH_COMPLIANCE: begin
                state_d = comply_code;
            end
            `LSR_PH_CFG_WIDTH: begin
                state_d = cfg_width_code;
            end
            `LSR_PH_CFG_LANE: begin
                state_d = cfg_lane_code;
            end
            `LSR_PH_CFG_DONE: begin
                state_d = cfg_done_code;
            end
            `LSR_PH_CFG_IDLE: begin
                state_d = `LSR_ST_CFG_IDLE;
            end
            `LSR_PH_L0: begin
                state_d = `LSR_ST_L0;
            end
            `LSR_PH_L1: begin
                if (l23_ready)
                    state_d = `LSR_ST_L23_READY;
                else
                    state_d = l1_code;
            end
            `LSR_PH_RECOVERY: begin
                state_d = recovery_code;
            end
            `LSR_PH_HOT_RESET: begin
                state_d = `LSR_ST_HOT_RESET;
            end
            `LSR_PH_DISABLED: begin
                state_d = disabled_code;
            end
            default: begin
                state_d = `LSR_ST_DETECT_QUIET;
            end
        endcase
    end

    // rate and width pass through regardless of link state; qualifying
    // them with the registered link-up copy is left to the user
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rate_q <= `LSR_RATE_RST;
        end else begin
            rate_q <= rate_d;
        end
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            width_q <= `LSR_WIDTH_RST;
        end else begin
            width_q <= width_d;
        end
    end

    // state code moves one cycle after the phase and step it was built from
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= `LSR_STATE_RST;
        end else begin
            state_q <= state_d;
        end
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            linkup_n_q <= `LSR_LINKUP_N_RST;
        end else begin
            linkup_n_q <= linkup_n_d;
        end
    end

    assign current_rate_report  = rate_q;
    assign current_width_report = width_q;
    assign training_state_code  = state_q;
    assign link_up_report_n     = linkup_n_q;

endmodule // lsr_top

`default_nettype wire

// [dv/lsr_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module lsr_checker (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       link_up_n,
    input wire logic       rate_is_5g,
    input wire logic [3:0] lane_count,
    input wire logic [3:0] train_phase,
    input wire logic [2:0] train_step,
    input wire logic       l23_ready,
    input wire logic       is_root_port,
    input wire logic       link_up_report_n,
    input wire logic       current_rate_report,
    input wire logic [1:0] current_width_report,
    input wire logic [5:0] training_state_code
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_RATE: assert property (1 |=> current_rate_report == $past(rate_is_5g))
        else $error("bad rate");
    AST_X8: assert property (lane_count == 4'h8 |=> current_width_report == 2'h3)
        else $error("bad width");
    AST_DET: assert property (train_phase == 4'h0 && train_step < 3'h4
        |=> training_state_code == $past(train_step)) else $error("bad detect");
    AST_CMP: assert property (train_phase == 4'h2 && train_step == 3'h4 |=>
        training_state_code == 6'h0a) else $error("bad compliance");
    AST_IDL: assert property (train_phase == 4'h6 |=> training_state_code == 6'h15)
        else $error("bad idle");
    AST_L23: assert property (train_phase == 4'h8 && l23_ready |=>
        training_state_code == 6'h19) else $error("bad l23");
    AST_HOT: assert property (train_phase == 4'ha |=> training_state_code == 6'h21)
        else $error("bad hot reset");
    AST_ROOT: assert property (train_phase == 4'h3 && train_step == 3'h0 && is_root_port
        |=> training_state_code == 6'h26) else $error("bad root code");
endmodule // lsr_checker
bind lsr_top lsr_checker i_lsr_checker (
    .clock                (clock),
    .reset_n              (reset_n),
    .link_up_n            (link_up_n),
    .rate_is_5g           (rate_is_5g),
    .lane_count           (lane_count),
    .train_phase          (train_phase),
    .train_step           (train_step),
    .l23_ready            (l23_ready),
    .is_root_port         (is_root_port),
    .link_up_report_n     (link_up_report_n),
    .current_rate_report  (current_rate_report),
    .current_width_report (current_width_report),
    .training_state_code  (training_state_code)
);
`default_nettype wire

// [dv/lsr_user_mon.sv]
`timescale 1ns/10ps
`default_nettype none
module lsr_user_mon (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       link_up_report_n,
    input wire logic       current_rate_report,
    input wire logic [1:0] current_width_report,
    output var logic       held_rate,
    output var logic [1:0] held_width
);
    // only trusts rate and width while the link is reported up
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            held_rate <= 1'h0;
            held_width <= 2'h0;
        end else if (!link_up_report_n) begin
            held_rate <= current_rate_report;
            held_width <= current_width_report;
        end
    end
endmodule // lsr_user_mon
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clock = 1'h0, reset_n = 1'h0, link_up_n = 1'h1, rate_is_5g = 1'h0;
    logic l23_ready = 1'h0, is_root_port = 1'h0, held_rate;
    logic [3:0] lane_count = 4'h1, train_phase = 4'h0;
    logic [2:0] train_step = 3'h0;
    logic [1:0] current_width_report, held_width;
    logic link_up_report_n, current_rate_report;
    logic [5:0] training_state_code;
    int bad_count = 0, checks_done = 0, i;
    always #5 clock = ~clock;
    lsr_top i_lsr_top (
        .clock                (clock),
        .reset_n              (reset_n),
        .link_up_n            (link_up_n),
        .rate_is_5g           (rate_is_5g),
        .lane_count           (lane_count),
        .train_phase          (train_phase),
        .train_step           (train_step),
        .l23_ready            (l23_ready),
        .is_root_port         (is_root_port),
        .link_up_report_n     (link_up_report_n),
        .current_rate_report  (current_rate_report),
        .current_width_report (current_width_report),
        .training_state_code  (training_state_code)
    );
    lsr_user_mon i_lsr_user_mon (
        .clock                (clock),
        .reset_n              (reset_n),
        .link_up_report_n     (link_up_report_n),
        .current_rate_report  (current_rate_report),
        .current_width_report (current_width_report),
        .held_rate            (held_rate),
        .held_width           (held_width)
    );
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task t(input logic [3:0] p, input logic [2:0] s, input logic [5:0] e);
        train_phase = p;
        train_step = s;
        @(posedge clock);
        #1;
        chk(training_state_code, e);
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        #1;
        reset_n = 1'h1;
        for (i = 0; i < 4; i++) t(4'h0, i[2:0], i[5:0]);
        for (i = 0; i < 2; i++) t(4'h1, i[2:0], 6'h04 + i[5:0]);
        for (i = 0; i < 5; i++) t(4'h2, i[2:0], 6'h06 + i[5:0]);
        for (i = 0; i < 4; i++) t(4'h3, i[2:0], 6'h0b + i[5:0]);
        for (i = 0; i < 2; i++) t(4'h4, i[2:0], 6'h0f + i[5:0]);
        for (i = 0; i < 4; i++) begin
            lane_count = 4'h1 << i[1:0];
            t(4'h5, 3'h0, 6'h11 + i[5:0]);
            chk(current_width_report, i[7:0]);
        end
        t(4'h6, 3'h0, 6'h15);
        t(4'h7, 3'h0, 6'h16);
        for (i = 0; i < 5; i++) t(4'h8, i[2:0], 6'h17 + i[5:0]);
        l23_ready = 1'h1;
        t(4'h8, 3'h0, 6'h19);
        for (i = 0; i < 5; i++) t(4'h9, i[2:0], 6'h1c + i[5:0]);
        t(4'ha, 3'h0, 6'h21);
        for (i = 0; i < 4; i++) t(4'hb, i[2:0], 6'h22 + i[5:0]);
        is_root_port = 1'h1;
        t(4'h3, 3'h0, 6'h26);
        $display("state code test done");
        rate_is_5g = 1'h1;
        link_up_n = 1'h0;
        repeat (2) t(4'h7, 3'h0, 6'h16);
        chk(current_rate_report, 8'h01);
        link_up_n = 1'h1;
        rate_is_5g = 1'h0;
        repeat (2) t(4'h7, 3'h0, 6'h16);
        chk(current_rate_report, 8'h00);
        chk({held_width, held_rate}, 8'h07);
        link_up_n = 1'h0;
        rate_is_5g = 1'h1;
        t(4'h7, 3'h0, 6'h16);
        chk(link_up_report_n, 8'h00);
        $display("rate and link test done");
        reset_n = 1'h0;
        #1;
        chk(current_width_report, 8'h00);
        chk(current_rate_report, 8'h00);
        chk(training_state_code, 8'h00);
        chk(link_up_report_n, 8'h01);
        @(posedge clock);
        #1;
        reset_n = 1'h1;
        t(4'h7, 3'h0, 6'h16);
        chk(current_width_report, 8'h03);
        chk(current_rate_report, 8'h01);
        $display("reset test done");
        results;
    end
    initial begin
        #20000;
        bad_count++;
        results;
    end
endmodule // tb_top
`default_nettype wire
